// [inc/pvic_pkg.sv]
// Constants, types and helpers for the priority vector interrupt controller
package pvic_pkg;

  // Number of request sources and of vector slots
  localparam int NUM_SRC = 19;
  localparam int NUM_VEC = 10;

  // Width of a vector address as presented to the core
  localparam int VEC_ADDR_W = 20;

  // First vector address and spacing between slots
  localparam logic [19:0] VEC_BASE = 20'h00003;
  localparam int VEC_SHIFT = 3;

  // Source positions inside the merged source flag word
  localparam int SRC_PIN_ZERO = 0;
  localparam int SRC_PIN_ONE = 1;
  localparam int SRC_PIN_TWO = 2;
  localparam int SRC_TIMER_ZERO_LOW = 3;
  localparam int SRC_PIN_FOUR = 4;
  localparam int SRC_PIN_THREE = 5;
  localparam int SRC_BASE_TIMER = 6;
  localparam int SRC_TIMER_ZERO_HIGH = 7;
  localparam int SRC_TIMER_ONE_LOW = 8;
  localparam int SRC_TIMER_ONE_HIGH = 9;
  localparam int SRC_SYNC_SERIAL_ZERO = 10;
  localparam int SRC_ASYNC_RECEIVE = 11;
  localparam int SRC_SERIAL_ONE = 12;
  localparam int SRC_ASYNC_TRANSMIT = 13;
  localparam int SRC_CONVERTER = 14;
  localparam int SRC_TIMER_SIX = 15;
  localparam int SRC_TIMER_SEVEN = 16;
  localparam int SRC_PWM = 17;
  localparam int SRC_PORT_ZERO = 18;

  // Which sources feed each vector slot, slot 0 at 00003H
  localparam logic [18:0] VEC_SRC_MASK [NUM_VEC] = '{
    19'h00001, // Pin interrupt zero
    19'h00002, // Pin interrupt one
    19'h0001c, // Pin two, timer zero low, pin four
    19'h00060, // Pin three, base timer
    19'h00080, // Timer zero high
    19'h00300, // Timer one both halves
    19'h00c00, // Sync serial zero, async receive
    19'h03000, // Serial one, async transmit
    19'h3c000, // Converter, timers six and seven, pwm
    19'h40000  // Port zero
  };

  // Slots that choose between highest and low rather than high and low
  localparam logic [9:0] VEC_TOP_CAPABLE = 10'h003;

  // Service levels, ordered none < low < high < highest
  typedef enum logic [1:0] {
    LVL_NONE = 2'h0,
    LVL_LOW = 2'h1,
    LVL_HIGH = 2'h2,
    LVL_TOP = 2'h3
  } level_t;

  // Controller state, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_OFFER = 2'h2
  } ctrl_state_t;

  // Reset values
  localparam logic [2:0] IN_SERVICE_RST = 3'h0;
  localparam logic [3:0] VEC_IDX_RST = 4'h0;

  // Level of a slot from its level select bit
  function automatic level_t vec_level(input int idx, input logic sel);
    if (!sel) begin
      return LVL_LOW;
    end
    return VEC_TOP_CAPABLE[idx] ? LVL_TOP : LVL_HIGH;
  endfunction

  // Highest level currently in service; stack bit n stands for level n+1
  function automatic level_t service_level(input logic [2:0] stack);
    if (stack[2]) begin
      return LVL_TOP;
    end
    if (stack[1]) begin
      return LVL_HIGH;
    end
    if (stack[0]) begin
      return LVL_LOW;
    end
    return LVL_NONE;
  endfunction

  // Vector address of a slot
  function automatic logic [19:0] vec_addr(input logic [3:0] idx);
    return VEC_BASE + {13'h0000, idx, 3'h0};
  endfunction

endpackage

// [hw/pvic_pick.sv]
// Combinational winner selection among pending vector slots
`timescale 1ns/100ps
module pvic_pick
  import pvic_pkg::*;
(
  input wire logic [9:0] vec_pending,
  input wire logic [9:0] vec_level_sel,
  input wire pvic_pkg::level_t floor_level,
  output logic win_valid,
  output logic [3:0] win_idx,
  output pvic_pkg::level_t win_level
);

  // Scan from the top slot down so the lowest eligible slot of a level wins
  always_comb begin
    level_t lvl;
    lvl = LVL_NONE;
    win_valid = 1'b0;
    win_idx = VEC_IDX_RST;
    win_level = LVL_NONE;
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      lvl = vec_level(i, vec_level_sel[i]); // R1
      if (vec_pending[i] && (lvl > floor_level) && (lvl >= win_level)) begin // R2 R3 R4
        win_valid = 1'b1;
        win_idx = 4'(i);
        win_level = lvl;
      end
    end
  end

endmodule

// [hw/pvic_ctrl.sv]
// Three-level nested vector interrupt controller with standby wake logic
//
// Summary of operation
// R1: Three nesting levels, highest above high above low.
// R2: Refuse requests not above the in-service level.
// R3: Simultaneous requests: highest level granted first.
// R4: Equal levels: lowest vector address wins.
// R5: Nineteen sources merged onto ten vectors.
// R6: Pin zero at 00003H, highest or low.
// R7: Pin one at 0000BH, highest or low.
// R8: Vectors 00013H to 0002BH: high or low.
// R9: Vectors 00033H to 0004BH: high or low.
// R10: Halt left on resets or accepted request.
// R11: Hold left on resets, pins zero to two and four, port zero.
// R12: Pins zero, one wake from hold and crystal hold only if level-detected.
// R13: Crystal hold also woken by base timer.
// R14: Shared vector requested by any enabled flag.
// R15: Reset leaves nothing in service or offered.
`timescale 1ns/100ps
module pvic_ctrl
  import pvic_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  // Source flags, level, held by the peripheral until its handler clears them
  input wire logic ext_pin_irq_zero,
  input wire logic ext_pin_irq_one,
  input wire logic ext_pin_irq_two,
  input wire logic ext_pin_irq_three,
  input wire logic ext_pin_irq_four,
  input wire logic timer_zero_low_event,
  input wire logic timer_zero_high_event,
  input wire logic timer_one_low_event,
  input wire logic timer_one_high_event,
  input wire logic timer_six_event,
  input wire logic timer_seven_event,
  input wire logic base_timer_event,
  input wire logic sync_serial_zero,
  input wire logic serial_one,
  input wire logic async_serial_port_rx,
  input wire logic async_serial_port_tx,
  input wire logic converter_event,
  input wire logic pwm_channel_a,
  input wire logic pwm_channel_b,
  input wire logic port_zero_event,
  // Per-source enables, bit positions as the source indices
  input wire logic [18:0] src_enable,
  // Per-slot level select: 1 picks highest (slots 0,1) or high, 0 picks low
  input wire logic [9:0] vec_level_sel,
  // Detection mode of pins zero and one: 1 = level, 0 = edge
  input wire logic pin_zero_level_mode,
  input wire logic pin_one_level_mode,
  // Core side handshake
  input wire logic irq_ack,
  input wire logic irq_return,
  // Standby state and reset causes
  input wire logic halt_mode,
  input wire logic hold_mode,
  input wire logic xtal_hold_mode,
  input wire logic reset_pin_n,
  input wire logic low_voltage_reset,
  input wire logic watchdog_reset,
  // Outputs to the core
  output logic irq_req_q,
  output logic [19:0] irq_vector_q,
  output pvic_pkg::level_t irq_level_q,
  output pvic_pkg::level_t service_level_q,
  output logic wake_q
);

  import pvic_pkg::*;

  // Whole controller state
  typedef struct packed {
    ctrl_state_t fsm;
    logic [2:0] in_service;
    logic [3:0] vec_idx;
    level_t req_level;
    logic req;
    logic [19:0] vec_addr;
    level_t svc_level;
    logic wake;
  } ctrl_t;

  ctrl_t st_q;
  ctrl_t st_d;

  logic [18:0] src_flags;
  logic [18:0] src_live;
  logic [9:0] vec_pending;
  logic win_valid;
  logic [3:0] win_idx;
  level_t win_level;
  level_t cur_level;
  logic reset_cause;
  logic hold_cause;
  logic xtal_cause;

  // Gather source flags into the indexed word
  always_comb begin
    src_flags = 19'h00000;
    src_flags[SRC_PIN_ZERO] = ext_pin_irq_zero;
    src_flags[SRC_PIN_ONE] = ext_pin_irq_one;
    src_flags[SRC_PIN_TWO] = ext_pin_irq_two;
    src_flags[SRC_TIMER_ZERO_LOW] = timer_zero_low_event;
    src_flags[SRC_PIN_FOUR] = ext_pin_irq_four;
    src_flags[SRC_PIN_THREE] = ext_pin_irq_three;
    src_flags[SRC_BASE_TIMER] = base_timer_event;
    src_flags[SRC_TIMER_ZERO_HIGH] = timer_zero_high_event;
    src_flags[SRC_TIMER_ONE_LOW] = timer_one_low_event;
    src_flags[SRC_TIMER_ONE_HIGH] = timer_one_high_event;
    src_flags[SRC_SYNC_SERIAL_ZERO] = sync_serial_zero;
    src_flags[SRC_ASYNC_RECEIVE] = async_serial_port_rx;
    src_flags[SRC_SERIAL_ONE] = serial_one;
    src_flags[SRC_ASYNC_TRANSMIT] = async_serial_port_tx;
    src_flags[SRC_CONVERTER] = converter_event;
    src_flags[SRC_TIMER_SIX] = timer_six_event;
    src_flags[SRC_TIMER_SEVEN] = timer_seven_event;
    src_flags[SRC_PWM] = pwm_channel_a | pwm_channel_b;
    src_flags[SRC_PORT_ZERO] = port_zero_event;
  end

  assign src_live = src_flags & src_enable;

  // Merge the sources onto their shared slots
  always_comb begin
    for (int v = 0; v < NUM_VEC; v++) begin
      vec_pending[v] = |(src_live & VEC_SRC_MASK[v]); // R5 R14
    end
  end

  // Level currently in service sets the floor for new requests
  assign cur_level = service_level(st_q.in_service); // R2

  // Winner among the pending slots above the floor
  pvic_pick u_pick (
    .vec_pending(vec_pending),
    .vec_level_sel(vec_level_sel), // R6 R7 R8 R9
    .floor_level(cur_level),
    .win_valid(win_valid),
    .win_idx(win_idx),
    .win_level(win_level)
  );

  // Wake causes; resets release every standby mode
  assign reset_cause = !reset_pin_n || low_voltage_reset || watchdog_reset; // R10 R11
  // Oscillators stop in hold, so only the documented pin and port causes count
  assign hold_cause = (src_live[SRC_PIN_ZERO] && pin_zero_level_mode) || // R12
                      (src_live[SRC_PIN_ONE] && pin_one_level_mode) || // R12
                      src_live[SRC_PIN_TWO] || src_live[SRC_PIN_FOUR] || // R11
                      src_live[SRC_PORT_ZERO]; // R11
  // Base timer keeps counting in crystal hold, so it may release it too
  assign xtal_cause = hold_cause || src_live[SRC_BASE_TIMER]; // R13

  // Next-state logic for offer, acceptance, return and wake
  always_comb begin
    st_d = st_q;
    case (st_q.fsm)
      ST_IDLE: begin
        if (win_valid) begin
          st_d.fsm = ST_OFFER;
          st_d.req = 1'b1;
          st_d.vec_idx = win_idx;
          st_d.req_level = win_level;
        end
      end
      ST_OFFER: begin
        if (irq_ack) begin
          // Push the granted level; it now blocks equal and lower levels
          st_d.in_service[st_q.req_level - 2'h1] = 1'b1; // R2
          st_d.fsm = ST_IDLE;
          st_d.req = 1'b0;
        end else if (win_valid) begin
          // A better request arriving before the core takes the offer replaces it
          st_d.vec_idx = win_idx; // R3 R4
          st_d.req_level = win_level;
        end else begin
          // No pending slot left above the floor before acceptance: withdraw the offer
          st_d.fsm = ST_IDLE;
          st_d.req = 1'b0;
        end
      end
      default: begin
        st_d.fsm = ST_IDLE;
        st_d.req = 1'b0;
      end
    endcase
    // Return pops the top level so the interrupted level resumes; a return in
    // the same cycle as an ack is dropped, so the level pushed above stays in service
    if (irq_return && !(st_q.fsm == ST_OFFER && irq_ack)) begin
      if (st_q.in_service[2]) begin
        st_d.in_service[2] = 1'b0; // R14
      end else if (st_q.in_service[1]) begin
        st_d.in_service[1] = 1'b0; // R14
      end else begin
        st_d.in_service[0] = 1'b0; // R14
      end
    end
    st_d.vec_addr = vec_addr(st_d.vec_idx);
    st_d.svc_level = service_level(st_d.in_service);
    // Wake is a level that follows the standby mode and its causes
    st_d.wake = reset_cause ||
                (halt_mode && win_valid) || // R10
                (hold_mode && hold_cause) || // R11
                (xtal_hold_mode && xtal_cause); // R13
  end

  // State register; nothing in service and no offer after reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q.fsm <= ST_IDLE; // R15
      st_q.in_service <= IN_SERVICE_RST; // R15
      st_q.vec_idx <= VEC_IDX_RST;
      st_q.req_level <= LVL_NONE;
      st_q.req <= 1'b0; // R15
      st_q.vec_addr <= VEC_BASE;
      st_q.svc_level <= LVL_NONE;
      st_q.wake <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state flops
  assign irq_req_q = st_q.req;
  assign irq_vector_q = st_q.vec_addr;
  assign irq_level_q = st_q.req_level;
  assign service_level_q = st_q.svc_level;
  assign wake_q = st_q.wake;

endmodule

// [sim/pvic_core_model.sv]
// Core-side model: takes offered vectors and signals handler returns
`timescale 1ns/100ps
module pvic_core_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic irq_req_q,
  input wire logic take,
  input wire logic slow_ack,
  input wire logic ret_go,
  output logic irq_ack,
  output logic irq_return
);
  logic seen_q;
  // One-cycle pulses; slow mode lets the offer stand a cycle first
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      seen_q <= irq_req_q && take;
      irq_ack <= take && irq_req_q && !irq_ack && (!slow_ack || seen_q);
      irq_return <= ret_go && !irq_return;
    end
  end
endmodule

// [sim/pvic_ctrl_chk.sv]
// Port checker for the priority vector interrupt controller
`timescale 1ns/100ps
module pvic_ctrl_chk
  import pvic_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic irq_ack,
  input wire logic irq_return,
  input wire logic halt_mode,
  input wire logic hold_mode,
  input wire logic xtal_hold_mode,
  input wire logic reset_pin_n,
  input wire logic low_voltage_reset,
  input wire logic watchdog_reset,
  input wire logic irq_req_q,
  input wire logic [19:0] irq_vector_q,
  input wire pvic_pkg::level_t irq_level_q,
  input wire pvic_pkg::level_t service_level_q,
  input wire logic wake_q
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  // Offer handshake and nesting
  ack_drop_a: assert property (irq_ack && irq_req_q |=> !irq_req_q)
    else $error("offer stayed up after acknowledge");
  take_level_a: assert property (irq_ack && irq_req_q |=> service_level_q == $past(irq_level_q))
    else $error("in-service level differs from taken level");
  offer_above_a: assert property (irq_req_q |-> irq_level_q > service_level_q)
    else $error("offer not above in-service level");
  // Vector grid, per-slot level choices and return pop
  vec_grid_a: assert property (irq_req_q |-> irq_vector_q[2:0] == 3'h3 && irq_vector_q <= 20'h0004b)
    else $error("vector outside the slot grid");
  top_slots_a: assert property (irq_req_q && irq_vector_q < 20'h00013 |-> irq_level_q != LVL_HIGH)
    else $error("pin slot offered at high");
  high_slots_a: assert property (irq_req_q && irq_vector_q > 20'h0000b |-> irq_level_q != LVL_TOP)
    else $error("shared slot offered at highest");
  return_pop_a: assert property (irq_return && !irq_ack && service_level_q == LVL_LOW
    |=> service_level_q == LVL_NONE)
    else $error("return did not restore level");
  // Wake is a registered copy of its causes
  cause_wake_a: assert property (!reset_pin_n || low_voltage_reset || watchdog_reset |=> wake_q)
    else $error("reset cause gave no wake");
  idle_wake_a: assert property (!(halt_mode || hold_mode || xtal_hold_mode) && reset_pin_n
    && !low_voltage_reset && !watchdog_reset |=> !wake_q)
    else $error("wake without standby or reset");
  cover property (irq_ack && irq_req_q);
  cover property (irq_return);
  cover property (wake_q && hold_mode);
  cover property (service_level_q == LVL_TOP);
endmodule

bind pvic_ctrl pvic_ctrl_chk chk_i (.*);

// [sim/tb_priority_vector_interrupt_ctrl.sv]
// Self-checking bench for the priority vector interrupt controller
`timescale 1ns/100ps
module tb_priority_vector_interrupt_ctrl;
  import pvic_pkg::*;
  logic ref_clk, nrst, take, slow_ack, ret_go, irq_ack, irq_return;
  logic ext_pin_irq_zero, ext_pin_irq_one, ext_pin_irq_two, ext_pin_irq_three;
  logic ext_pin_irq_four, timer_zero_low_event, timer_zero_high_event, timer_one_low_event;
  logic timer_one_high_event, timer_six_event, timer_seven_event, base_timer_event;
  logic sync_serial_zero, serial_one, async_serial_port_rx, async_serial_port_tx;
  logic converter_event, pwm_channel_a, pwm_channel_b, port_zero_event;
  logic [18:0] src_enable;
  logic [9:0] vec_level_sel;
  logic pin_zero_level_mode, pin_one_level_mode, halt_mode, hold_mode, xtal_hold_mode;
  logic reset_pin_n, low_voltage_reset, watchdog_reset, irq_req_q, wake_q;
  logic [19:0] irq_vector_q;
  level_t irq_level_q, service_level_q;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  int slot [19] = '{0, 1, 2, 2, 2, 3, 3, 4, 5, 5, 6, 6, 7, 7, 8, 8, 8, 8, 9};
  // Case word: halt hold xtal rst_low lvr wdr pin0 mode0 base port0 enable expect
  logic [11:0] wake_cases [11] = '{12'h802, 12'h103, 12'h083, 12'h043, 12'h807,
    12'h804, 12'h422, 12'h433, 12'h40a, 12'h20b, 12'h222};

  pvic_ctrl DUT (.*);
  pvic_core_model core_i (.*);

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Hang guard, well above the expected run length
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic tick;
    @(posedge ref_clk);
    #2;
  endtask

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic set_src(input logic [18:0] s);
    {port_zero_event, pwm_channel_b, timer_seven_event, timer_six_event, converter_event,
     async_serial_port_tx, serial_one, async_serial_port_rx, sync_serial_zero,
     timer_one_high_event, timer_one_low_event, timer_zero_high_event, base_timer_event,
     ext_pin_irq_three, ext_pin_irq_four, timer_zero_low_event, ext_pin_irq_two,
     ext_pin_irq_one, ext_pin_irq_zero} = s;
  endtask

  task automatic apply_case(input logic [11:0] c);
    {halt_mode, hold_mode, xtal_hold_mode} = c[11:9];
    reset_pin_n = !c[8];
    {low_voltage_reset, watchdog_reset} = c[7:6];
    pin_zero_level_mode = c[4];
    src_enable = {19{c[1]}};
    set_src({c[2], 11'h000, c[3], 5'h00, c[5]});
  endtask

  // Three ticks leave room for the slow take but not a second one
  task automatic do_ack(input logic slow);
    slow_ack = slow;
    take = 1'b1;
    repeat (3) tick;
    take = 1'b0;
  endtask

  task automatic do_ret;
    ret_go = 1'b1;
    tick;
    ret_go = 1'b0;
    tick;
    tick;
  endtask

  task automatic t_reset;
    chk(irq_req_q, 1'b0);
    chk(irq_vector_q, 20'h00003);
    chk(irq_level_q, LVL_NONE);
    chk(service_level_q, LVL_NONE);
    chk(wake_q, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_vectors;
    level_t lv;
    for (int s = 0; s < 2; s++) begin
      vec_level_sel = s ? 10'h3ff : 10'h000;
      for (int i = 0; i < 19; i++) begin
        set_src(19'h00001 << i);
        tick;
        lv = !s ? LVL_LOW : (slot[i] < 2 ? LVL_TOP : LVL_HIGH);
        chk(irq_req_q, 1'b1);
        chk(irq_vector_q, 20'h00003 + 20'(8 * slot[i]));
        chk(irq_level_q, lv);
        set_src(19'h00000);
        tick;
        tick;
      end
    end
    // Pwm channel a, not driven by set_src, shares the merged pwm source
    pwm_channel_a = 1'b1;
    tick;
    chk(irq_vector_q, 20'h00043);
    pwm_channel_a = 1'b0;
    tick;
    tick;
    vec_level_sel = 10'h3ff;
    $display("test vectors done");
  endtask

  task automatic t_nest;
    vec_level_sel = 10'h3fb;
    set_src(19'h40024);
    tick;
    chk(irq_vector_q, 20'h0001b);
    chk(irq_level_q, LVL_HIGH);
    do_ack(1'b0);
    chk(service_level_q, LVL_HIGH);
    set_src(19'h40004);
    tick;
    chk(irq_req_q, 1'b0);
    set_src(19'h40005);
    tick;
    chk(irq_level_q, LVL_TOP);
    do_ack(1'b1);
    chk(service_level_q, LVL_TOP);
    set_src(19'h40004);
    do_ret;
    chk(service_level_q, LVL_HIGH);
    chk(irq_req_q, 1'b0);
    do_ret;
    chk(irq_vector_q, 20'h0004b);
    // Higher source clears while offered; the low pin slot takes its place
    set_src(19'h00004);
    tick;
    chk(irq_vector_q, 20'h00013);
    chk(irq_level_q, LVL_LOW);
    do_ack(1'b0);
    chk(service_level_q, LVL_LOW);
    set_src(19'h00000);
    do_ret;
    chk(service_level_q, LVL_NONE);
    set_src(19'h00000);
    vec_level_sel = 10'h3ff;
    tick;
    tick;
    $display("test nest done");
  endtask

  task automatic t_wake;
    for (int k = 0; k < 11; k++) begin
      apply_case(wake_cases[k]);
      tick;
      chk(wake_q, wake_cases[k][0]);
      apply_case(12'h002);
      tick;
      tick;
    end
    // Pins one, two and four under hold; a timer source must not wake
    hold_mode = 1'b1;
    for (int k = 0; k < 5; k++) begin
      pin_one_level_mode = (k == 0);
      set_src(k < 2 ? 19'h00002 : (k == 2 ? 19'h00004 : (k == 3 ? 19'h00010 : 19'h08000)));
      tick;
      chk(wake_q, k != 1 && k != 4);
      set_src(19'h00000);
      tick;
      tick;
    end
    hold_mode = 1'b0;
    pin_one_level_mode = 1'b0;
    $display("test wake done");
  endtask

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    {take, slow_ack, ret_go, pwm_channel_a, pin_one_level_mode} = 5'h00;
    vec_level_sel = 10'h3ff;
    apply_case(12'h002);
    repeat (12) @(posedge ref_clk);
    #2;
    nrst = 1'b1;
    t_reset;
    t_vectors;
    t_nest;
    t_wake;
    summarize();
  end
endmodule
